// *** hw/vcd_pkg.sv ***
// Constants and types for the calibration DAC two-wire slave
// Notes on behaviour
// RQ1 - Read returns seven DAC bits then a zero bit.
// RQ2 - Master writes seven-bit code then a one; device loads the DAC.
// RQ3 - Write byte ending in zero is a program command; other bits ignored.
// RQ4 - No program and no acknowledge unless gate-on supply exceeds threshold.
// RQ5 - Code zero gives most sink current; all ones gives least; monotonic.
// RQ6 - Once addressed, device acknowledges every received byte; a refused program byte gets no acknowledge.
// RQ7 - Master gives one extra clock per byte for the acknowledge.
// RQ8 - Acknowledger holds data low through the acknowledge clock high phase.
// RQ9 - Master withholds acknowledge to end read; device releases data high.
// RQ10 - No acknowledge of anything while the program cycle runs.
// RQ11 - Master polls with start and address; acknowledge only when done.
// RQ12 - Master sends a write before any program command.
// RQ13 - Program ignored and not acknowledged unless setting changed since.
// RQ14 - Address byte is seven-bit code then direction bit, one is read.
// RQ15 - Each transfer is address byte plus one data byte, start to stop.
// RQ16 - Address acknowledged only on match and when not programming.
// RQ17 - Reset loads DAC from stored value and clears modified flag.
package vcd_pkg;
  localparam int DAC_W = 7;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic RW_READ = 1'b1;
  localparam logic LAST_WRITE = 1'b1;
  localparam logic LAST_READ = 1'b0;
  localparam logic [6:0] DAC_FULL = 7'h7f;
  // Program cycle length; arbitrary neutral default
  localparam int PROG_TIME_US = 300;
  localparam int CLK_MHZ = 10;
  localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK,
    ST_WAIT
  } vcd_state_t;
  typedef struct packed {
    logic [6:0] code;
    logic [6:0] sink;
  } vcd_dac_t;
endpackage

// *** hw/vcd_i2c_slave.sv ***
// Two-wire slave for the calibration DAC setting with nonvolatile commit
`timescale 1ns/100ps
`default_nettype none
module vcd_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2a, // Arbitrary device code
  parameter int PROG_CYCLES = vcd_pkg::PROG_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic gate_on_supply_ok_in,
  input wire logic [6:0] nv_stored_in,
  output var vcd_pkg::vcd_dac_t dac_out,
  output logic nv_write_out,
  output logic [6:0] nv_data_out,
  output logic prog_busy_out
);
  import vcd_pkg::*;

  // Refused at elaboration: a zero-length program cycle or a zero code
  if (PROG_CYCLES < 1 || DEV_ADDR == 7'h00) begin : g_bad_param
    $error("vcd_i2c_slave: bad parameters");
  end

  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  vcd_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [6:0] dac;
  logic modified;
  logic loaded;
  logic busy;
  logic [31:0] prog_cnt;
  logic sup_s1;
  logic sup_ok;
  logic drive_low;
  logic [7:0] rd_byte;

  // Synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      sup_s1 <= 1'b0;
      sup_ok <= 1'b0;
    end else if (ce_in) begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      sup_s1 <= gate_on_supply_ok_in;
      sup_ok <= sup_s1;
    end
  end

  assign scl = scl_s[1];
  assign sda = sda_s[1];
  assign scl_rise = scl && !scl_s[2];
  assign scl_fall = !scl && scl_s[2];
  assign start_c = scl && scl_s[2] && !sda && sda_s[2];
  assign stop_c = scl && scl_s[2] && sda && !sda_s[2];
  assign rd_byte = {dac, LAST_READ}; // RQ1

  // Bus sequencer; data changes on SCL fall, sampled on rise
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      drive_low <= 1'b0;
    end else if (ce_in) begin
      if (stop_c) begin
        state <= ST_IDLE; // RQ15
        drive_low <= 1'b0;
      end else if (start_c) begin
        state <= ST_ADDR;
        bitcnt <= 4'h0;
        drive_low <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_WDATA: begin
            shreg <= {shreg[6:0], sda};
            bitcnt <= bitcnt + 4'h1;
          end
          ST_RACK: begin
            // RQ9 master nack ends read; either way release
            state <= ST_WAIT;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (bitcnt == BIT_ACK) begin
              if (shreg[7:1] == DEV_ADDR && !busy) begin // RQ16 RQ10 RQ11
                state <= ST_ADDR_ACK;
                drive_low <= 1'b1; // RQ6 RQ8
              end else begin
                state <= ST_WAIT; // RQ14
              end
            end
          end
          ST_ADDR_ACK: begin
            bitcnt <= 4'h0;
            if (shreg[0] == RW_READ) begin // RQ14
              state <= ST_RDATA;
              shreg <= {rd_byte[6:0], 1'b0};
              drive_low <= !rd_byte[7]; // RQ1
            end else begin
              state <= ST_WDATA;
              drive_low <= 1'b0;
            end
          end
          ST_WDATA: begin
            if (bitcnt == BIT_ACK) begin
              state <= ST_WACK;
              // RQ3 RQ4 RQ13 program acknowledged only when allowed
              drive_low <= (shreg[0] == LAST_WRITE) ||
                           (sup_ok && modified);
            end
          end
          ST_WACK: begin
            state <= ST_WAIT; // RQ15
            drive_low <= 1'b0;
          end
          ST_RDATA: begin
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == 4'h7) begin
              state <= ST_RACK;
              drive_low <= 1'b0; // RQ9
            end else begin
              drive_low <= !shreg[7];
              shreg <= {shreg[6:0], 1'b0};
            end
          end
          default: begin
            drive_low <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain data pin: only ever pulls low
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (ce_in) begin
      sda_out <= 1'b0;
      sda_oe_out <= drive_low; // RQ8
    end
  end

  // DAC setting, modified flag and program cycle
  logic wbyte_done;
  assign wbyte_done = ce_in && scl_fall && state == ST_WDATA &&
                      bitcnt == BIT_ACK;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dac <= 7'h00;
      loaded <= 1'b0;
      modified <= 1'b0;
      busy <= 1'b0;
      prog_cnt <= 32'h0;
      nv_write_out <= 1'b0;
      nv_data_out <= 7'h00;
    end else if (ce_in) begin
      nv_write_out <= 1'b0;
      if (!loaded) begin
        dac <= nv_stored_in; // RQ17
        loaded <= 1'b1;
        modified <= 1'b0;
      end else if (wbyte_done && shreg[0] == LAST_WRITE) begin
        dac <= shreg[7:1]; // RQ2
        modified <= 1'b1; // RQ13
      end else if (wbyte_done && sup_ok && modified) begin // RQ4 RQ13
        busy <= 1'b1; // RQ3 other bits ignored
        modified <= 1'b0;
        nv_write_out <= 1'b1;
        nv_data_out <= dac;
        prog_cnt <= 32'(PROG_CYCLES - 1);
      end else if (busy) begin
        if (prog_cnt == 32'h0) begin
          busy <= 1'b0; // RQ11
        end else begin
          prog_cnt <= prog_cnt - 32'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dac_out <= '0;
      prog_busy_out <= 1'b0;
    end else if (ce_in) begin
      dac_out.code <= dac;
      dac_out.sink <= DAC_FULL - dac; // RQ5
      prog_busy_out <= busy;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_wbyte_prog;
    wbyte_done && shreg[0] != LAST_WRITE;
  endsequence

  property p_no_ack_busy;
    ce_in && scl_fall && state == ST_ADDR && bitcnt == BIT_ACK && busy
      |=> state == ST_WAIT && !drive_low;
  endproperty
  a_no_ack_busy: assert property (p_no_ack_busy) // RQ10
    else $error("addressed while programming");

  property p_prog_gate;
    s_wbyte_prog ##0 (!sup_ok || !modified) |=> !busy && !drive_low;
  endproperty
  a_prog_gate: assert property (p_prog_gate) // RQ4
    else $error("program not refused");

  property p_prog_start;
    s_wbyte_prog ##0 (sup_ok && modified && !busy)
      |=> busy && nv_write_out && !modified;
  endproperty
  a_prog_start: assert property (p_prog_start) // RQ13
    else $error("program did not start");

  property p_write_load;
    wbyte_done && shreg[0] == LAST_WRITE && loaded
      |=> dac == $past(shreg[7:1]) && modified;
  endproperty
  a_write_load: assert property (p_write_load) // RQ2
    else $error("write not loaded");

  property p_sink;
    ce_in |=> dac_out.sink + dac_out.code == $past(DAC_FULL) || !$past(ce_in);
  endproperty
  a_sink: assert property (p_sink) // RQ5
    else $error("sink mapping wrong");

  property p_addr_ack;
    ce_in && scl_fall && state == ST_ADDR && bitcnt == BIT_ACK &&
      shreg[7:1] == DEV_ADDR && !busy |=> drive_low ##1 sda_oe_out;
  endproperty
  a_addr_ack: assert property (p_addr_ack) // RQ16
    else $error("address not acknowledged");

  property p_rack_release;
    state == ST_RACK |-> !drive_low;
  endproperty
  a_rack_release: assert property (p_rack_release) // RQ9
    else $error("line held in master ack");

  property p_last_zero;
    // The final bit is a zero, so the line must be pulled low
    ce_in && scl_fall && state == ST_RDATA && bitcnt == 4'h6
      |=> drive_low;
  endproperty
  a_last_zero: assert property (p_last_zero) // RQ1
    else $error("final read bit not zero");

  property p_reload;
    !loaded && ce_in |=> loaded && !modified;
  endproperty
  a_reload: assert property (p_reload) // RQ17
    else $error("reset load failed");
endmodule
`default_nettype wire

// *** verif/vcd_master_model.sv ***
// Two-wire bus master model that drives the DAC slave
`timescale 1ns/100ps
`default_nettype none
module vcd_master_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic hp(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Data moves only well after the clock fall, so no false start or stop
  task automatic clk_bit(input logic b, output logic r);
    hp(3);
    sda_low_out = ~b;
    hp(8);
    scl_out = 1'b1;
    hp(10);
    r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] v, output logic [7:0] r,
    output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], r[i]);
    // Master releases data in the ninth clock; a read ends unacknowledged
    clk_bit(1'b1, n);
    ack = ~n;
  endtask
  task automatic xfer(input logic [6:0] a, input logic rd,
    input logic [7:0] d, output logic aa, output logic ad,
    output logic [7:0] q);
    logic [7:0] t;
    hp(10);
    sda_low_out = 1'b1;
    hp(10);
    scl_out = 1'b0;
    send_byte({a, rd}, t, aa);
    ad = 1'b0;
    q = 8'h00;
    // Program commands follow a write, except where t_unmod sends one with no write since the last program and t_reload sends one after a reset
    if (aa) send_byte(rd ? 8'hff : d, q, ad);
    hp(3);
    sda_low_out = 1'b1;
    hp(10);
    scl_out = 1'b1;
    hp(10);
    sda_low_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verif/vcom_dac_i2c_slave_tb.sv ***
// Self-checking bench for the calibration DAC two-wire slave
`timescale 1ns/100ps
`default_nettype none
module vcom_dac_i2c_slave_tb;
  import vcd_pkg::*;
  localparam logic [6:0] ADR = 7'h2a;
  logic clk_in, rstn_in, gate, scl, m_low, sda_o, sda_oe, nv_wr, busy;
  logic aa, ad, ce;
  logic [7:0] q;
  logic [6:0] nv_data;
  // Stored value seen by the block; follows every commit it makes
  logic [6:0] nv_d = 7'h15;
  vcd_dac_t dac;
  wire sda = !(m_low || (sda_oe && !sda_o));
  int num_errors = 0;
  int check_count = 0;
  int nv_cnt = 0;
  vcd_i2c_slave #(.DEV_ADDR(ADR), .PROG_CYCLES(400)) i_vcd_i2c_slave (
    .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .gate_on_supply_ok_in(gate), .nv_stored_in(nv_d), .dac_out(dac),
    .nv_write_out(nv_wr), .nv_data_out(nv_data), .prog_busy_out(busy));
  vcd_master_model i_vcd_master_model (.clk_in(clk_in), .sda_in(sda),
    .scl_out(scl), .sda_low_out(m_low));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (nv_wr === 1'b1) begin
      nv_cnt <= nv_cnt + 1;
      nv_d <= nv_data;
    end
  end
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic xf(input logic [6:0] a, input logic rd, input logic [7:0] d);
    i_vcd_master_model.xfer(a, rd, d, aa, ad, q);
  endtask
  task automatic t_read(input logic [6:0] c);
    xf(ADR, RW_READ, 8'h00);
    chk(aa === 1'b1, "read address not acknowledged");
    chk(q === {c, LAST_READ}, "read byte wrong");
    chk(ad === 1'b0, "data line not released");
  endtask
  task automatic t_write();
    logic [6:0] c;
    for (int i = 0; i < 2; i++) begin
      c = i ? DAC_FULL : 7'h00;
      xf(ADR, 1'b0, {c, LAST_WRITE});
      chk(aa === 1'b1 && ad === 1'b1, "write not acknowledged");
      chk(dac.code === c, "code not loaded");
      chk(dac.sink === DAC_FULL - c, "sink not inverse");
    end
  endtask
  task automatic t_addr();
    xf(ADR ^ 7'h01, 1'b0, 8'h01);
    chk(aa === 1'b0, "foreign address acknowledged");
  endtask
  task automatic t_gate();
    gate = 1'b0;
    xf(ADR, 1'b0, 8'haa);
    chk(ad === 1'b0 && nv_cnt === 0, "program with low gate");
    gate = 1'b1;
  endtask
  task automatic t_prog();
    xf(ADR, 1'b0, 8'h54);
    chk(ad === 1'b1 && nv_cnt === 1, "program refused");
    chk(nv_d === DAC_FULL && dac.code === DAC_FULL, "bits used");
    chk(busy === 1'b1, "no program cycle");
    xf(ADR, RW_READ, 8'h00);
    chk(aa === 1'b0, "acknowledged while busy");
    for (int i = 0; i < 6 && aa !== 1'b1; i++) xf(ADR, RW_READ, 8'h00);
    chk(aa === 1'b1 && q === {DAC_FULL, 1'b0}, "poll failed");
  endtask
  task automatic t_unmod();
    xf(ADR, 1'b0, 8'h00);
    chk(ad === 1'b0 && nv_cnt === 1, "unmodified program taken");
  endtask
  task automatic t_freeze();
    // Let the stop settle first so the frozen synchronisers hold idle
    repeat (5) @(posedge clk_in);
    #1;
    ce = 1'b0;
    xf(ADR, 1'b0, {7'h33, LAST_WRITE});
    chk(aa === 1'b0 && dac.code === DAC_FULL, "state moved while frozen");
    ce = 1'b1;
  endtask
  task automatic t_reload();
    xf(ADR, 1'b0, {7'h33, LAST_WRITE});
    chk(ad === 1'b1 && dac.code === 7'h33, "write after freeze");
    rstn_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    repeat (10) @(posedge clk_in);
    chk(dac.code === DAC_FULL, "committed value not reloaded");
    xf(ADR, 1'b0, 8'h00);
    chk(aa === 1'b1 && ad === 1'b0 && nv_cnt === 1, "flag kept");
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    num_errors++;
    stop_test();
  end
  initial begin
    rstn_in = 1'b0;
    gate = 1'b1;
    ce = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    repeat (10) @(posedge clk_in);
    chk(dac.code === 7'h15 && dac.sink === 7'h6a, "reset load");
    t_read(7'h15);
    t_write();
    t_addr();
    t_gate();
    t_prog();
    t_unmod();
    t_freeze();
    t_reload();
    stop_test();
  end
endmodule
`default_nettype wire
